// ==== hw/qeq_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - bus answered only while select pin high
// - all config registers readable and writable
// - bus stays alive while lanes are standby
// - behaves as standard management bus slave
// - RO writes ignored, RW stored and returned
// - offset 0: revision high, present flags low
// - offset 1: lanes 1/0 applied on and boost
// - offset 2: lanes 3/2 applied on and boost
// - offset 3: lanes 1/0 enable boost, 0x44
// - offset 4: lanes 3/2 enable boost, 0x44
// - offset 5: four on-threshold codes per lane
// - offset 6: four off-threshold codes per lane
// - offset 7: register control enable bit
// - offset 8: swing code bits 3:2, 0x78
// - lane state from pin or register bit
// - boost from pins or per-lane registers
// - present set above on, cleared below off
module qeq_regs #(
  parameter logic [6:0] BUS_ADDR       = 7'h5A, // arbitrary value
  parameter logic [3:0] REVISION_ID    = 4'h3,  // arbitrary value
  parameter int         TIMEOUT_CYCLES = qeq_pkg::TIMEOUT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        port_select_pin,
  input  wire logic        mgmt_clock_pin,
  input  wire logic        mgmt_data_in,
  output logic             mgmt_data_out,
  output logic             mgmt_data_oe_n,
  input  wire logic [3:0]  lane_on_pin,
  input  wire logic        boost_source_pin,
  input  wire logic [2:0]  boost_select_pins,
  input  wire logic [3:0]  lane_above_on,
  input  wire logic [3:0]  lane_below_off,
  output logic             lane0_on,
  output logic             lane1_on,
  output logic             lane2_on,
  output logic             lane3_on,
  output logic [11:0]      boost_code,
  output logic             lane0_signal_present,
  output logic             lane1_signal_present,
  output logic             lane2_signal_present,
  output logic             lane3_signal_present,
  output logic [7:0]       detect_on_threshold,
  output logic [7:0]       detect_off_threshold,
  output logic [1:0]       output_swing_code
);

  import qeq_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] sync_pins;
  logic              scl_s;
  logic              sda_s;
  logic              cs_s;
  logic [3:0]        on_pin_s;
  logic              src_s;
  logic [2:0]        bst_s;
  logic [3:0]        above_s;
  logic [3:0]        below_s;
  assign raw_pins = {mgmt_clock_pin, mgmt_data_in, port_select_pin,
                     lane_on_pin, boost_source_pin, boost_select_pins,
                     lane_above_on, lane_below_off};
  qeq_sync #(
    .W        (SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );
  assign {scl_s, sda_s, cs_s, on_pin_s, src_s, bst_s, above_s,
          below_s} = sync_pins;

  // ----------------------------------------------------------------
  // bus edge and condition detection
  // ----------------------------------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  assign scl_rise  = scl_s && !scl_prev_q;
  assign scl_fall  = !scl_s && scl_prev_q;
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------
  // clock low timeout
  // ----------------------------------------------------------------
  qeq_state_type      st_q;
  logic [TOUT_W-1:0]  tout_q;
  logic               timeout;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tout_q <= '0;
    end else if (st_q == ST_IDLE || scl_s) begin
      tout_q <= '0;
    end else if (!timeout) begin
      tout_q <= tout_q + 1'b1;
    end
  end
  assign timeout = (tout_q == TOUT_W'(TIMEOUT_CYCLES - 1));

  // ----------------------------------------------------------------
  // bus slave state machine
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic       rw_q;
  logic       nack_q;
  logic       drive_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_data;
  logic       byte_done;
  logic       wr_fire;
  logic       rd_next;
  assign byte_done = scl_fall && (bit_cnt_q == BYTE_BITS);
  assign wr_fire   = byte_done && (st_q == ST_WR);
  assign rd_next   = byte_done && (st_q == ST_RD);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
      drive_q   <= 1'b0;
    end else if (!cs_s || bus_stop || timeout) begin
      st_q    <= ST_IDLE;
      drive_q <= 1'b0;
    end else if (bus_start) begin
      st_q      <= ST_ADDR;
      bit_cnt_q <= '0;
      drive_q   <= 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        ST_ADDR, ST_CMD, ST_WR: begin
          shift_q   <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
        ST_RD_ACK: nack_q <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (byte_done && shift_q[7:1] == BUS_ADDR) begin
            st_q    <= ST_ADDR_ACK;
            rw_q    <= shift_q[0];
            drive_q <= 1'b1;
          end else if (byte_done) begin
            st_q <= ST_IDLE;
          end
        end
        ST_CMD, ST_WR: begin
          if (byte_done) begin
            st_q    <= (st_q == ST_CMD) ? ST_CMD_ACK : ST_WR_ACK;
            drive_q <= 1'b1;
          end
        end
        ST_ADDR_ACK: begin
          if (rw_q) begin
            st_q      <= ST_RD;
            shift_q   <= rd_data;
            drive_q   <= !rd_data[7];
            bit_cnt_q <= FIRST_SENT;
          end else begin
            st_q      <= ST_CMD;
            drive_q   <= 1'b0;
            bit_cnt_q <= '0;
          end
        end
        ST_CMD_ACK, ST_WR_ACK: begin
          st_q      <= ST_WR;
          drive_q   <= 1'b0;
          bit_cnt_q <= '0;
        end
        ST_RD: begin
          if (byte_done) begin
            st_q    <= ST_RD_ACK;
            drive_q <= 1'b0;
          end else begin
            shift_q   <= {shift_q[6:0], 1'b0};
            drive_q   <= !shift_q[6];
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
        end
        ST_RD_ACK: begin
          if (nack_q) begin
            st_q <= ST_IDLE;
          end else begin
            st_q      <= ST_RD;
            shift_q   <= rd_data;
            drive_q   <= !rd_data[7];
            bit_cnt_q <= FIRST_SENT;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  assign mgmt_data_out  = 1'b0;
  assign mgmt_data_oe_n = !drive_q;
  // register pointer: set by command byte, steps after each data byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (byte_done && st_q == ST_CMD && cs_s) begin
      ptr_q <= shift_q;
    end else if ((wr_fire || rd_next) && cs_s) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] en_boost01_q;
  logic [7:0] en_boost23_q;
  logic [7:0] on_thr_q;
  logic [7:0] off_thr_q;
  logic       reg_ctrl_q;
  logic [7:0] swing_q;
  logic       wr_ok;
  assign wr_ok = wr_fire && cs_s && !bus_stop && !timeout;
  // status offsets 0..2 have no storage, so writes there drop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_boost01_q <= RST_ENABLE_BOOST;
      en_boost23_q <= RST_ENABLE_BOOST;
      on_thr_q     <= RST_DETECT_THR;
      off_thr_q    <= RST_DETECT_THR;
      reg_ctrl_q   <= RST_REG_CONTROL;
      swing_q      <= RST_OUTPUT_SWING;
    end else if (wr_ok) begin
      case (ptr_q)
        OFF_LANES01_ENABLE_BOOST:  en_boost01_q <= shift_q;
        OFF_LANES23_ENABLE_BOOST:  en_boost23_q <= shift_q;
        OFF_DETECT_ON_THRESHOLDS:  on_thr_q     <= shift_q;
        OFF_DETECT_OFF_THRESHOLDS: off_thr_q    <= shift_q;
        OFF_REGISTER_CONTROL_SEL:
          reg_ctrl_q <= shift_q[CTRL_EN_BIT];
        OFF_OUTPUT_SWING:          swing_q      <= shift_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  logic [3:0]  act_v;
  logic [3:0]  pres_v;
  logic [11:0] bst_v;
  logic [15:0] en_boost_all;
  assign en_boost_all = {en_boost23_q, en_boost01_q};
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    qeq_lane u_lane (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .pin_on          (on_pin_s[i]),
      .reg_mode        (reg_ctrl_q),
      .reg_standby     (en_boost_all[i*NIBBLE_W+EN_IN_NIB]),
      .boost_from_pins (src_s),
      .pin_boost       (bst_s),
      .reg_boost       (en_boost_all[i*NIBBLE_W +: BOOST_W]),
      .above_on        (above_s[i]),
      .below_off       (below_s[i]),
      .active          (act_v[i]),
      .boost           (bst_v[i*BOOST_W +: BOOST_W]),
      .present         (pres_v[i])
    );
  end
  assign {lane3_on, lane2_on, lane1_on, lane0_on} = act_v;
  assign {lane3_signal_present, lane2_signal_present,
          lane1_signal_present, lane0_signal_present} = pres_v;
  assign boost_code           = bst_v;
  assign detect_on_threshold  = on_thr_q;
  assign detect_off_threshold = off_thr_q;
  assign output_swing_code    = swing_q[SWING_LSB +: SWING_W];

  // ----------------------------------------------------------------
  // read mux, built from live lane state
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = READ_ZERO;
    case (ptr_q)
      OFF_LANE_SIGNAL_STATUS:
        rd_data = {REVISION_ID, pres_v};
      OFF_LANES01_APPLIED_STATE:
        rd_data = {act_v[1], bst_v[5:3], act_v[0], bst_v[2:0]};
      OFF_LANES23_APPLIED_STATE:
        rd_data = {act_v[3], bst_v[11:9], act_v[2], bst_v[8:6]};
      OFF_LANES01_ENABLE_BOOST:  rd_data = en_boost01_q;
      OFF_LANES23_ENABLE_BOOST:  rd_data = en_boost23_q;
      OFF_DETECT_ON_THRESHOLDS:  rd_data = on_thr_q;
      OFF_DETECT_OFF_THRESHOLDS: rd_data = off_thr_q;
      OFF_REGISTER_CONTROL_SEL:  rd_data = {7'h00, reg_ctrl_q};
      OFF_OUTPUT_SWING:          rd_data = swing_q;
      default:                   rd_data = READ_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_addr_hit;
    st_q == ST_ADDR && byte_done && shift_q[7:1] == BUS_ADDR && cs_s
      && !bus_stop && !timeout;
  endsequence
  sequence s_ack_release;
    st_q == ST_CMD_ACK && scl_fall && cs_s && !bus_stop && !timeout;
  endsequence
  a_select_gates_bus: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !cs_s |=> st_q == ST_IDLE && mgmt_data_oe_n)
    else $error("bus active while select low");
  a_addr_ack_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_addr_hit |=> !mgmt_data_oe_n && st_q == ST_ADDR_ACK)
    else $error("address not acknowledged");
  a_ack_then_free: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_ack_release |=> mgmt_data_oe_n && st_q == ST_WR)
    else $error("data line held after acknowledge");
  a_rw_write_store: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_ok && ptr_q == OFF_LANES01_ENABLE_BOOST
      |=> en_boost01_q == $past(shift_q))
    else $error("write not stored");
  a_status_live: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ptr_q == OFF_LANE_SIGNAL_STATUS |-> rd_data == {REVISION_ID, pres_v})
    else $error("status read not live");
  a_ctrl_reserved: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ptr_q == OFF_REGISTER_CONTROL_SEL |-> rd_data[7:1] == 7'h00)
    else $error("reserved control bits not zero");
  a_bus_in_standby: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ((act_v == 4'h0) and s_addr_hit) |=> !mgmt_data_oe_n)
    else $error("bus dead in standby");
  a_ptr_step: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rd_next && cs_s && !bus_stop && !timeout)
      |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");

endmodule : qeq_regs

// ==== hw/qeq_pkg.sv ====
package qeq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LANE_SIGNAL_STATUS     = 8'h00;
  localparam logic [7:0] OFF_LANES01_APPLIED_STATE  = 8'h01;
  localparam logic [7:0] OFF_LANES23_APPLIED_STATE  = 8'h02;
  localparam logic [7:0] OFF_LANES01_ENABLE_BOOST   = 8'h03;
  localparam logic [7:0] OFF_LANES23_ENABLE_BOOST   = 8'h04;
  localparam logic [7:0] OFF_DETECT_ON_THRESHOLDS   = 8'h05;
  localparam logic [7:0] OFF_DETECT_OFF_THRESHOLDS  = 8'h06;
  localparam logic [7:0] OFF_REGISTER_CONTROL_SEL   = 8'h07;
  localparam logic [7:0] OFF_OUTPUT_SWING           = 8'h08;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE_BOOST = 8'h44;
  localparam logic [7:0] RST_DETECT_THR   = 8'h00;
  localparam logic       RST_REG_CONTROL  = 1'b0;
  localparam logic [7:0] RST_OUTPUT_SWING = 8'h78;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int NUM_LANES   = 4;
  localparam int BOOST_W     = 3;
  localparam int THR_W       = 2;
  localparam int NIBBLE_W    = 4;
  localparam int EN_IN_NIB   = 3;
  localparam int CTRL_EN_BIT = 0;
  localparam int SWING_LSB   = 2;
  localparam int SWING_W     = 2;

  // ----------------------------------------------------------------
  // bus framing and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] FIRST_SENT  = 4'h1;
  localparam int TIMEOUT_MS          = 25;
  localparam int CLK_KHZ             = 100000;
  localparam int TIMEOUT_CYC         = TIMEOUT_MS * CLK_KHZ;
  localparam int TOUT_W              = 22;
  localparam int SYNC_W              = 19;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } qeq_state_type;

endpackage : qeq_pkg

// ==== hw/qeq_sync.sv ====
`timescale 1ns/1ps
module qeq_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : qeq_sync

// ==== hw/qeq_lane.sv ====
`timescale 1ns/1ps
module qeq_lane
  import qeq_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         pin_on,
  input  wire logic         reg_mode,
  input  wire logic         reg_standby,
  input  wire logic         boost_from_pins,
  input  wire logic [2:0]   pin_boost,
  input  wire logic [2:0]   reg_boost,
  input  wire logic         above_on,
  input  wire logic         below_off,
  output logic              active,
  output logic [2:0]        boost,
  output logic              present
);

  // ----------------------------------------------------------------
  // applied lane state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (reg_mode) begin
      active <= !reg_standby;
    end else begin
      active <= pin_on;
    end
  end

  // boost level 000 minimum to 111 maximum
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boost <= '0;
    end else if (boost_from_pins) begin
      boost <= pin_boost;
    end else begin
      boost <= reg_boost;
    end
  end

  // hysteresis flag: set above on level, clear below off level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      present <= 1'b0;
    end else if (above_on) begin
      present <= 1'b1;
    end else if (below_off) begin
      present <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_lane_state_src: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_mode |=> active == !$past(reg_standby))
    else $error("lane state does not follow register bit");

  a_boost_pin_src: assert property (
    @(posedge mclk) disable iff (!rst_n)
    boost_from_pins |=> boost == $past(pin_boost))
    else $error("boost not taken from pins");

  a_detect_hyst: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (below_off && !above_on) |=> !present)
    else $error("signal present not cleared");

endmodule : qeq_lane

// ==== tb/qeq_host.sv ====
`timescale 1ns/1ps
module qeq_host (
  output logic      scl,
  output logic      sda,
  input  wire logic sda_wire
);
  // ----------------------------------------------------------------
  // management bus host, idle lines released high
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic bit_out(input logic b);
    sda = b;
    #31.25 scl = 1'b1;
    #62.5 scl = 1'b0;
    #31.25;
  endtask : bit_out

  // releases the line and samples mid high phase
  task automatic bit_in(output logic b);
    sda = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 b = sda_wire;
    #31.25 scl = 1'b0;
    #31.25;
  endtask : bit_in

  task automatic start();
    sda = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda = 1'b0;
    #62.5 scl = 1'b0;
    #31.25;
  endtask : start

  task automatic stop();
    sda = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda = 1'b1;
    #125;
  endtask : stop

  task automatic byte_out(input logic [7:0] v, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_in(nack);
  endtask : byte_out

  task automatic byte_in(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
  endtask : byte_in

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ok);
    logic n0, n1, n2;
    start();
    byte_out({dev, 1'b0}, n0);
    byte_out(ptr, n1);
    byte_out(d, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic ok);
    logic n0, n1, n2;
    start();
    byte_out({dev, 1'b0}, n0);
    byte_out(ptr, n1);
    start();
    byte_out({dev, 1'b1}, n2);
    byte_in(d, 1'b1);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : read_reg
endmodule : qeq_host

// ==== tb/qeq_regs_bench.sv ====
`timescale 1ns/1ps
module qeq_regs_bench;
  import qeq_pkg::*;
  localparam logic [6:0] DEV = 7'h2C; // arbitrary bus address
  localparam logic [3:0] REV = 4'h9;  // arbitrary revision
  logic        mclk, rst_n, sel, scl, sda_h, feb, dout, oe_n, ok, nack;
  logic        l0, l1, l2, l3, p0, p1, p2, p3;
  logic [3:0]  pin_on, above, below;
  logic [2:0]  bsel;
  logic [11:0] boost;
  logic [7:0]  on_thr, off_thr, rd;
  logic [1:0]  swing;
  wire logic   sda_w;
  int          miscompares, checked, m[9], pres[4];
  int unsigned seed = 32'h9191551D;

  // open-drain data line with pull-up
  assign sda_w = sda_h & (oe_n | dout);

  qeq_regs #(
    .BUS_ADDR       (DEV),
    .REVISION_ID    (REV),
    .TIMEOUT_CYCLES (2000)
  ) uut (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .port_select_pin      (sel),
    .mgmt_clock_pin       (scl),
    .mgmt_data_in         (sda_w),
    .mgmt_data_out        (dout),
    .mgmt_data_oe_n       (oe_n),
    .lane_on_pin          (pin_on),
    .boost_source_pin     (feb),
    .boost_select_pins    (bsel),
    .lane_above_on        (above),
    .lane_below_off       (below),
    .lane0_on             (l0),
    .lane1_on             (l1),
    .lane2_on             (l2),
    .lane3_on             (l3),
    .boost_code           (boost),
    .lane0_signal_present (p0),
    .lane1_signal_present (p1),
    .lane2_signal_present (p2),
    .lane3_signal_present (p3),
    .detect_on_threshold  (on_thr),
    .detect_off_threshold (off_thr),
    .output_swing_code    (swing)
  );

  qeq_host host (
    .scl      (scl),
    .sda      (sda_h),
    .sda_wire (sda_w)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic int unsigned nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  function automatic int on(int i);
    if (m[7][0]) return !m[3 + i / 2][i % 2 * 4 + 3];
    return pin_on[i];
  endfunction : on

  function automatic int bst(int i);
    return feb ? bsel : m[3 + i / 2] >> (i % 2 * 4) & 7;
  endfunction : bst

  function automatic int st(int r);
    int a = r == 2 ? 2 : 0;
    if (r == 0) return REV * 16 + pres[3] * 8 + pres[2] * 4
                       + pres[1] * 2 + pres[0];
    if (r > 8) return 0;
    if (r > 2) return m[r];
    return (on(a + 1) * 8 + bst(a + 1)) * 16 + on(a) * 8 + bst(a);
  endfunction : st

  task automatic check(input string n, input logic [11:0] s,
                       input logic [11:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wr(input int r, input int v);
    v = v & 255;
    host.write_reg(DEV, 8'(r), 8'(v), ok);
    check("write ack", 12'(ok), 12'h1);
    if (r > 2 && r < 9) m[r] = r == 7 ? v & 1 : v;
  endtask : wr

  task automatic rdc(input int r);
    host.read_reg(DEV, 8'(r), rd, ok);
    check("read ack", 12'(ok), 12'h1);
    check($sformatf("reg %0d", r), 12'(rd), 12'(st(r)));
  endtask : rdc

  task automatic lanes();
    int e;
    repeat (6) @(posedge mclk);
    #1;
    e = 0;
    for (int i = 0; i < 4; i++) begin
      e = e | on(i) << (4 + i) | pres[i] << i;
      check("boost", 12'(boost[3*i+:3]), 12'(bst(i)));
    end
    check("lane flags", 12'({l3, l2, l1, l0, p3, p2, p1, p0}),
          12'(e));
    check("on thr", 12'(on_thr), 12'(m[5]));
    check("off thr", 12'(off_thr), 12'(m[6]));
    check("swing", 12'(swing), 12'(m[8] >> 2 & 3));
  endtask : lanes

  task automatic drive(input int k);
    logic [3:0] up, dn;
    up = 4'(nxt());
    dn = 4'(nxt());
    @(posedge mclk);
    #1;
    pin_on = 4'(nxt());
    bsel = 3'(nxt());
    feb = k[1];
    above = up;
    below = dn;
    for (int i = 0; i < 4; i++) begin
      if (up[i]) pres[i] = 1;
      else if (dn[i]) pres[i] = 0;
    end
  endtask : drive

  task end_of_test();
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    sel = 1'b1;
    feb = 1'b1;
    bsel = 3'h4;
    pin_on = 4'h0;
    above = 4'h0;
    below = 4'h0;
    miscompares = 0;
    checked = 0;
    m = '{0, 0, 0, 'h44, 'h44, 0, 0, 0, 'h78};
    pres = '{0, 0, 0, 0};
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    lanes();
    for (int r = 0; r < 10; r++) rdc(r);
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 10; r++) wr(r, nxt());
      wr(7, 'hFE | k);
      drive(k);
      lanes();
      for (int r = 0; r < 10; r++) rdc(r);
    end
    @(posedge mclk);
    #1 sel = 1'b0;
    host.write_reg(DEV, 8'h03, 8'h5A, ok);
    check("deselected ack", 12'(ok), 12'h0);
    @(posedge mclk);
    #1 sel = 1'b1;
    host.write_reg(DEV ^ 7'h01, 8'h03, 8'h5A, ok);
    check("wrong address ack", 12'(ok), 12'h0);
    host.start();
    host.byte_out({DEV, 1'b0}, nack);
    host.byte_out(8'h05, nack);
    #25000;
    host.byte_out(8'hFF, nack);
    check("stalled clock nack", 12'(nack), 12'h1);
    host.stop();
    rdc(3);
    rdc(5);
    m[5] = nxt() & 255;
    m[6] = nxt() & 255;
    host.start();
    host.byte_out({DEV, 1'b0}, nack);
    host.byte_out(8'h05, nack);
    host.byte_out(8'(m[5]), nack);
    host.byte_out(8'(m[6]), nack);
    check("burst write ack", 12'(nack), 12'h0);
    host.stop();
    host.start();
    host.byte_out({DEV, 1'b0}, nack);
    host.byte_out(8'h05, nack);
    host.start();
    host.byte_out({DEV, 1'b1}, nack);
    host.byte_in(rd, 1'b0);
    check("burst first", 12'(rd), 12'(st(5)));
    host.byte_in(rd, 1'b1);
    check("burst second", 12'(rd), 12'(st(6)));
    host.stop();
    end_of_test();
  end

  // run normally ends near 500 us
  initial begin
    #800000;
    miscompares++;
    end_of_test();
  end
endmodule : qeq_regs_bench
